// >>> logic/solat_params.svh
// constants for the strap option latch
`ifndef SOLAT_PARAMS_SVH
`define SOLAT_PARAMS_SVH
`define SOLAT_ADDR_CTRL     12'h000
`define SOLAT_ADDR_ADV      12'h004
`define SOLAT_ADDR_STRAP    12'h008
`define SOLAT_ADDR_OPT      12'h00C
`define SOLAT_ADDR_STATUS   12'h010
`define SOLAT_ADDR_OUTFN    12'h014
`define SOLAT_CTRL_SPEED    13
`define SOLAT_CTRL_ANEG     12
`define SOLAT_CTRL_DUPLEX   8
`define SOLAT_ADV_100FD     8
`define SOLAT_ADV_100HD     7
`define SOLAT_ADV_10FD      6
`define SOLAT_ADV_10HD      5
`define SOLAT_CTRL_RST      16'h3100
`define SOLAT_ADV_RST       16'h01E1
`define SOLAT_ADDR_DEFAULT  5'h01
`define SOLAT_OPT_LPBK      0
`define SOLAT_OPT_ISO       1
`define SOLAT_OPT_RMII      2
`define SOLAT_OPT_BTB       3
`define SOLAT_OPT_NOFEF     4
`endif

// >>> logic/solat_pkg.sv
// types for the strap option latch
package solat_pkg;
	typedef struct packed {
		logic [4:0] mgmt_address_strap;
		logic       coding_loopback_strap;
		logic       isolate_strap;
		logic       reduced_mii_strap;
		logic       reduced_mii_back_to_back_strap;
		logic       speed_select_strap;
		logic       duplex_strap;
		logic       autoneg_enable_strap;
	} solat_straps_t;
	typedef enum logic [1:0] {
		SOLAT_CAPTURE = 2'b00,
		SOLAT_RUN     = 2'b01
	} solat_state_t;
endpackage

// >>> logic/solat_top.sv
// strap option latch with apb register access
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "solat_params.svh"
module solat_top (
	input  wire logic        MCLK,
	input  wire logic        RESET_N,
	input  wire logic [11:0] PADDR,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [11:0] STRAP_IN,
	output logic      [11:0] STRAP_OUT,
	output logic      [11:0] STRAP_OE,
	input  wire logic        FIBER_MODE_ENABLE,
	input  wire logic        POWER_DOWN_N,
	input  wire logic        LINK_100,
	output logic      [4:0]  MGMT_ADDRESS,
	output logic      [15:0] CTRL_BITS,
	output logic      [15:0] ADV_BITS,
	output logic      [4:0]  OPTION_BITS,
	output logic             POWER_DOWN
);
	// strap pin order: [4:0] address, 5 loopback, 6 isolate, 7 rmii,
	// 8 back-to-back, 9 speed, 10 duplex, 11 autoneg
	logic [11:0] sync1_ff;
	logic [11:0] sync2_ff;
	logic        fx_sync1_ff;
	logic        fx_sync2_ff;
	logic        pd_sync1_ff;
	logic        pd_sync2_ff;
	logic        lk_sync1_ff;
	logic        lk_sync2_ff;
	solat_pkg::solat_state_t state_ff;
	solat_pkg::solat_straps_t latched_ff;
	logic [15:0] ctrl_ff;
	logic [15:0] adv_ff;
	logic [4:0]  opt_ff;
	logic [15:0] outfn_ff;
	logic        load_ff;
	logic        settle_ff;
	logic        wr_en;
	logic        rd_en;
	logic        hit;
	logic [31:0] nxt_rdata;

	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] b);
		addr_is = (a == b);
	endfunction

	// two-flop synchronisers for the pin levels
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sync1_ff <= 12'h000;
			sync2_ff <= 12'h000;
			fx_sync1_ff <= 1'b0;
			fx_sync2_ff <= 1'b0;
			pd_sync1_ff <= 1'b1;
			pd_sync2_ff <= 1'b1;
			lk_sync1_ff <= 1'b0;
			lk_sync2_ff <= 1'b0;
		end else begin
			sync1_ff <= STRAP_IN;
			sync2_ff <= sync1_ff;
			fx_sync1_ff <= FIBER_MODE_ENABLE;
			fx_sync2_ff <= fx_sync1_ff;
			pd_sync1_ff <= POWER_DOWN_N;
			pd_sync2_ff <= pd_sync1_ff;
			lk_sync1_ff <= LINK_100;
			lk_sync2_ff <= lk_sync1_ff;
		end
	end

	// wait until the synchronisers hold pin levels, then load once and run
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_ff <= solat_pkg::SOLAT_CAPTURE;
			load_ff <= 1'b0;
			settle_ff <= 1'b0;
		end else begin
			load_ff <= 1'b0;
			case (state_ff)
				solat_pkg::SOLAT_CAPTURE: begin
					if (load_ff) begin
						state_ff <= solat_pkg::SOLAT_RUN;
					end else if (settle_ff) begin
						load_ff <= 1'b1;
					end else begin
						settle_ff <= 1'b1;
					end
				end
				solat_pkg::SOLAT_RUN: begin
					state_ff <= solat_pkg::SOLAT_RUN;
				end
				default: begin
					state_ff <= solat_pkg::SOLAT_CAPTURE;
				end
			endcase
		end
	end

	// latch straps from synchronised pins, three edges after release
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			latched_ff <= '{mgmt_address_strap: `SOLAT_ADDR_DEFAULT, speed_select_strap: 1'b1,
				duplex_strap: 1'b1, autoneg_enable_strap: 1'b1, default: 1'b0};
		end else if (load_ff) begin
			latched_ff.mgmt_address_strap <= sync2_ff[4:0];
			latched_ff.coding_loopback_strap <= sync2_ff[5];
			latched_ff.isolate_strap <= sync2_ff[6];
			latched_ff.reduced_mii_strap <= sync2_ff[7];
			latched_ff.reduced_mii_back_to_back_strap <= sync2_ff[8];
			latched_ff.speed_select_strap <= sync2_ff[9];
			latched_ff.duplex_strap <= sync2_ff[10];
			latched_ff.autoneg_enable_strap <= sync2_ff[11];
		end
	end

	assign wr_en = PSEL & PENABLE & PWRITE;
	assign rd_en = PSEL & PENABLE & ~PWRITE;
	assign hit = addr_is(PADDR, `SOLAT_ADDR_CTRL) | addr_is(PADDR, `SOLAT_ADDR_ADV)
		| addr_is(PADDR, `SOLAT_ADDR_STRAP) | addr_is(PADDR, `SOLAT_ADDR_OPT)
		| addr_is(PADDR, `SOLAT_ADDR_STATUS) | addr_is(PADDR, `SOLAT_ADDR_OUTFN);

	// control, advertisement and option bits: strap load then software
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_ff <= `SOLAT_CTRL_RST;
			adv_ff <= `SOLAT_ADV_RST;
			opt_ff <= 5'h00;
		end else if (state_ff == solat_pkg::SOLAT_CAPTURE && load_ff) begin
			ctrl_ff <= `SOLAT_CTRL_RST;
			ctrl_ff[`SOLAT_CTRL_SPEED] <= sync2_ff[9];
			ctrl_ff[`SOLAT_CTRL_DUPLEX] <= sync2_ff[10];
			ctrl_ff[`SOLAT_CTRL_ANEG] <= sync2_ff[11];
			adv_ff[`SOLAT_ADV_100FD] <= sync2_ff[9] & sync2_ff[10];
			adv_ff[`SOLAT_ADV_100HD] <= sync2_ff[9];
			adv_ff[`SOLAT_ADV_10FD] <= sync2_ff[10];
			adv_ff[`SOLAT_ADV_10HD] <= 1'b1;
			opt_ff[`SOLAT_OPT_LPBK] <= sync2_ff[5];
			opt_ff[`SOLAT_OPT_ISO] <= sync2_ff[6];
			opt_ff[`SOLAT_OPT_RMII] <= sync2_ff[7];
			opt_ff[`SOLAT_OPT_BTB] <= sync2_ff[8];
			opt_ff[`SOLAT_OPT_NOFEF] <= fx_sync2_ff & ~sync2_ff[9];
		end else if (wr_en && state_ff == solat_pkg::SOLAT_RUN) begin
			if (addr_is(PADDR, `SOLAT_ADDR_CTRL)) begin
				ctrl_ff <= PWDATA[15:0];
			end
			if (addr_is(PADDR, `SOLAT_ADDR_ADV)) begin
				adv_ff <= PWDATA[15:0];
			end
			if (addr_is(PADDR, `SOLAT_ADDR_OPT)) begin
				opt_ff <= PWDATA[4:0];
			end
		end
	end

	// software-driven output function values for the shared pins other than pin 9
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			outfn_ff <= 16'h0000;
		end else if (wr_en && addr_is(PADDR, `SOLAT_ADDR_OUTFN)) begin
			outfn_ff <= PWDATA[15:0];
		end
	end

	// pins: released during reset and capture, driven afterwards
	always_comb begin
		STRAP_OE = (state_ff == solat_pkg::SOLAT_RUN) ? 12'hFFF : 12'h000;
		STRAP_OUT = outfn_ff[11:0];
		STRAP_OUT[9] = ~lk_sync2_ff;
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (addr_is(PADDR, `SOLAT_ADDR_CTRL)) nxt_rdata[15:0] = ctrl_ff;
		if (addr_is(PADDR, `SOLAT_ADDR_ADV)) nxt_rdata[15:0] = adv_ff;
		if (addr_is(PADDR, `SOLAT_ADDR_STRAP)) nxt_rdata[11:0] = latched_ff;
		if (addr_is(PADDR, `SOLAT_ADDR_OPT)) nxt_rdata[4:0] = opt_ff;
		if (addr_is(PADDR, `SOLAT_ADDR_STATUS)) nxt_rdata[1:0] = {~pd_sync2_ff, state_ff[0]};
		if (addr_is(PADDR, `SOLAT_ADDR_OUTFN)) nxt_rdata[15:0] = outfn_ff;
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			PRDATA <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			PRDATA <= nxt_rdata;
		end
	end

	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~hit;
	assign MGMT_ADDRESS = latched_ff.mgmt_address_strap;
	assign CTRL_BITS = ctrl_ff;
	assign ADV_BITS = adv_ff;
	assign OPTION_BITS = opt_ff;
	assign POWER_DOWN = ~pd_sync2_ff;

	AST_OE_IN_CAPTURE: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(state_ff != solat_pkg::SOLAT_RUN) |-> (STRAP_OE == 12'h000))
		else $error("strap pins driven during capture");
	AST_OE_RUN: assert property (@(posedge MCLK) disable iff (!RESET_N)
		$rose(state_ff == solat_pkg::SOLAT_RUN) |-> STRAP_OE == 12'hFFF)
		else $error("strap pins not driven after capture");
	AST_SETTLE: assert property (@(posedge MCLK) disable iff (!RESET_N)
		$rose(load_ff) |-> settle_ff)
		else $error("straps loaded before synchronisers settled");
	AST_LOAD_ONCE: assert property (@(posedge MCLK) disable iff (!RESET_N)
		load_ff |=> !load_ff && state_ff == solat_pkg::SOLAT_RUN)
		else $error("strap load not followed by run");
	AST_ADDR: assert property (@(posedge MCLK) disable iff (!RESET_N)
		load_ff |=> MGMT_ADDRESS == $past(sync2_ff[4:0]))
		else $error("address strap not latched");
	AST_STRAP_HOLD: assert property (@(posedge MCLK) disable iff (!RESET_N)
		state_ff == solat_pkg::SOLAT_RUN |=> $stable(MGMT_ADDRESS))
		else $error("latched address changed while running");
	AST_SPEED: assert property (@(posedge MCLK) disable iff (!RESET_N)
		load_ff |=> CTRL_BITS[13] == $past(sync2_ff[9]))
		else $error("speed bit not latched");
	AST_DUPLEX: assert property (@(posedge MCLK) disable iff (!RESET_N)
		load_ff |=> CTRL_BITS[8] == $past(sync2_ff[10]))
		else $error("duplex bit not latched");
	AST_ANEG: assert property (@(posedge MCLK) disable iff (!RESET_N)
		load_ff |=> CTRL_BITS[12] == $past(sync2_ff[11]))
		else $error("autoneg bit not latched");
	AST_ADV: assert property (@(posedge MCLK) disable iff (!RESET_N)
		load_ff |=> ADV_BITS[7] == $past(sync2_ff[9]) && ADV_BITS[6] == $past(sync2_ff[10]))
		else $error("advertisement not latched");
	AST_OPTS: assert property (@(posedge MCLK) disable iff (!RESET_N)
		load_ff |=> OPTION_BITS[3:0] == $past(sync2_ff[8:5]))
		else $error("option straps not latched");
	AST_NOFEF: assert property (@(posedge MCLK) disable iff (!RESET_N)
		load_ff |=> OPTION_BITS[4] == $past(fx_sync2_ff & ~sync2_ff[9]))
		else $error("far end fault option wrong");
	AST_LED: assert property (@(posedge MCLK) disable iff (!RESET_N)
		STRAP_OUT[9] == ~lk_sync2_ff)
		else $error("speed led wrong");
	AST_PD: assert property (@(posedge MCLK) disable iff (!RESET_N)
		POWER_DOWN != pd_sync2_ff)
		else $error("power down wrong");
	AST_OUTFN: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(wr_en && addr_is(PADDR, `SOLAT_ADDR_OUTFN))
		|=> STRAP_OUT[8:0] == $past(PWDATA[8:0]))
		else $error("pin output function not written");
	AST_SWWR: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(wr_en && state_ff == solat_pkg::SOLAT_RUN && addr_is(PADDR, `SOLAT_ADDR_CTRL))
		|=> CTRL_BITS == $past(PWDATA[15:0]))
		else $error("software write lost");
	AST_ADV_WR: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(wr_en && state_ff == solat_pkg::SOLAT_RUN && addr_is(PADDR, `SOLAT_ADDR_ADV))
		|=> ADV_BITS == $past(PWDATA[15:0]))
		else $error("advertisement write lost");
	AST_OPT_WR: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(wr_en && state_ff == solat_pkg::SOLAT_RUN && addr_is(PADDR, `SOLAT_ADDR_OPT))
		|=> OPTION_BITS == $past(PWDATA[4:0]))
		else $error("option write lost");

	// bus checks
	AST_RDATA: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(rd_en && $past(PSEL && !PENABLE)) |-> PRDATA == $past(nxt_rdata))
		else $error("read data not loaded at setup");
	AST_UNMAPPED: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(rd_en && !hit) |-> PRDATA == 32'h0000_0000 && PSLVERR)
		else $error("unmapped read not refused");
	AST_PRDATA_HOLD: assert property (@(posedge MCLK) disable iff (!RESET_N)
		!$past(PSEL && !PENABLE && !PWRITE) |-> $stable(PRDATA))
		else $error("read data changed outside setup");
	AST_STATUS: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(rd_en && addr_is(PADDR, `SOLAT_ADDR_STATUS))
		|-> PRDATA[1:0] == {$past(POWER_DOWN), $past(state_ff == solat_pkg::SOLAT_RUN)})
		else $error("status read wrong");

	COV_CAPTURE: cover property (@(posedge MCLK) disable iff (!RESET_N) load_ff);
	COV_WRITE: cover property (@(posedge MCLK) disable iff (!RESET_N)
		wr_en && addr_is(PADDR, `SOLAT_ADDR_CTRL));
	COV_NOFEF: cover property (@(posedge MCLK) disable iff (!RESET_N) OPTION_BITS[4]);
	COV_RUN: cover property (@(posedge MCLK) disable iff (!RESET_N)
		$rose(state_ff == solat_pkg::SOLAT_RUN));
	COV_SLVERR: cover property (@(posedge MCLK) disable iff (!RESET_N) PSLVERR);
endmodule
`default_nettype wire

// >>> verif/solat_strap_board.sv
// board strap resistors and pin levels seen by the strap latch
`timescale 1ns/10ps
`default_nettype none
module solat_strap_board (
	input  wire logic [11:0] fit_mask,
	input  wire logic [11:0] fit_level,
	input  wire logic [11:0] pin_out,
	input  wire logic [11:0] pin_oe,
	output logic      [11:0] pin_level
);
	// internal pulls: address bit 0, speed, duplex and autoneg up, the rest down
	localparam logic [11:0] PULLS = 12'hE01;
	// driven pin follows the device, else a fitted resistor, else the pull
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & fit_mask & fit_level)
		| (~pin_oe & ~fit_mask & PULLS);
endmodule
`default_nettype wire

// >>> verif/tb_strap_option_latch.sv
// random strap capture and register tests for the strap option latch
`timescale 1ns/10ps
`default_nettype none
module tb_strap_option_latch;
	logic        mclk, reset_n, psel, penable, pwrite, fiber, pdn, link, pslverr, pready;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [11:0] strap_in, strap_out, strap_oe, fit_mask, fit_level, lvl;
	logic [4:0]  mgmt_addr, opt;
	logic [15:0] ctrl, adv;
	logic        pwr_down;
	int          err_total, n_compared;
	// board reset pulse of 50us at the 25ns clock
	localparam int RST_HOLD = 2000;

	solat_top u_dut (.MCLK(mclk), .RESET_N(reset_n), .PADDR(paddr), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .STRAP_IN(strap_in), .STRAP_OUT(strap_out),
		.STRAP_OE(strap_oe), .FIBER_MODE_ENABLE(fiber), .POWER_DOWN_N(pdn),
		.LINK_100(link), .MGMT_ADDRESS(mgmt_addr), .CTRL_BITS(ctrl), .ADV_BITS(adv),
		.OPTION_BITS(opt), .POWER_DOWN(pwr_down));
	solat_strap_board u_board (.fit_mask(fit_mask), .fit_level(fit_level),
		.pin_out(strap_out), .pin_oe(strap_oe), .pin_level(strap_in));

	initial mclk = 1'b0;
	always #12.5 mclk = ~mclk;

	function automatic logic [15:0] exp_ctrl(input logic [11:0] s);
		return {2'b00, s[9], s[11], 3'b000, s[10], 8'h00};
	endfunction
	function automatic logic [15:0] exp_adv(input logic [11:0] s);
		return {7'h00, s[9] & s[10], s[9], s[10], 1'b1, 5'h01};
	endfunction
	function automatic logic [4:0] exp_opt(input logic [11:0] s, input logic f);
		return {f & ~s[9], s[8], s[7], s[6], s[5]};
	endfunction
	function automatic logic [11:0] exp_strap(input logic [11:0] s);
		return {s[4:0], s[5], s[6], s[7], s[8], s[9], s[10], s[11]};
	endfunction

	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 50)
			err_total++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic run_case(input int k);
		logic [31:0] r, w;
		logic        e;
		@(posedge mclk);
		reset_n <= 1'b0;
		fit_mask <= (k == 0) ? 12'h000 : (k < 3) ? 12'hFFF : 12'($urandom);
		fit_level <= (k == 1) ? 12'hFFF : (k == 2) ? 12'h000 : 12'($urandom);
		fiber <= 1'($urandom);
		pdn <= 1'($urandom);
		link <= 1'($urandom);
		repeat (RST_HOLD) @(posedge mclk);
		chk("oe in reset", 32'h0, strap_oe);
		chk("ctrl in reset", 32'h3100, ctrl);
		lvl = (fit_mask & fit_level) | (~fit_mask & 12'hE01);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		chk("oe running", 32'hFFF, strap_oe);
		chk("address", lvl[4:0], mgmt_addr);
		chk("control", exp_ctrl(lvl), ctrl);
		chk("advert", exp_adv(lvl), adv);
		chk("options", exp_opt(lvl, fiber), opt);
		apb(1'b0, 12'h008, 32'h0, r, e);
		chk("straps", exp_strap(lvl), r);
		apb(1'b0, 12'h010, 32'h0, r, e);
		chk("status", {30'h0, !pdn, 1'b1}, r);
		w = $urandom;
		apb(1'b1, 12'h000, w, r, e);
		apb(1'b0, 12'h000, 32'h0, r, e);
		chk("ctrl read", w & 32'hFFFF, r);
		chk("ctrl port", w & 32'hFFFF, ctrl);
		apb(1'b1, 12'h004, ~w, r, e);
		apb(1'b0, 12'h004, 32'h0, r, e);
		chk("adv read", ~w & 32'hFFFF, r);
		chk("adv port", ~w & 32'hFFFF, adv);
		apb(1'b1, 12'h00C, w, r, e);
		apb(1'b0, 12'h00C, 32'h0, r, e);
		chk("opt read", w & 32'h1F, r);
		chk("opt port", w & 32'h1F, opt);
		apb(1'b1, 12'h014, w, r, e);
		apb(1'b0, 12'h014, 32'h0, r, e);
		chk("outfn read", w & 32'hFFFF, r);
		chk("out function", w[11:0] & 12'hDFF, strap_out & 12'hDFF);
		apb(1'b0, 12'h018, 32'h0, r, e);
		chk("unmapped err", 32'h1, e);
		chk("unmapped read", 32'h0, r);
		for (int t = 0; t < 2; t++) begin
			chk("power down", !pdn, pwr_down);
			chk("speed led", !link, strap_out[9]);
			pdn <= ~pdn;
			link <= ~link;
			repeat (4) @(posedge mclk);
		end
	endtask

	initial begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		fiber = 1'b0;
		pdn = 1'b1;
		link = 1'b0;
		fit_mask = 11'h000;
		fit_level = 11'h000;
		err_total = 0;
		n_compared = 0;
		void'($urandom(11));
		for (int k = 0; k < 8; k++)
			run_case(k);
		print_verdict;
	end

	initial begin
		repeat (30000) @(posedge mclk);
		err_total++;
		print_verdict;
	end
endmodule
`default_nettype wire
